/* design/umdp_pkg.sv */
// umdp_pkg: constants and carrier types of the modem, dma and pin logic
// assumes: one 200 MHz clock domain, axi4-lite register access, 32-bit data
package umdp_pkg;

   // register byte offsets
   localparam logic [7:0] UMDP_OFF_MCTRL = 8'h00;
   localparam logic [7:0] UMDP_OFF_MSTAT = 8'h04;
   localparam logic [7:0] UMDP_OFF_DMA = 8'h08;
   localparam logic [7:0] UMDP_OFF_IRQ_STAT = 8'h0C;
   localparam logic [7:0] UMDP_OFF_IRQ_MASK = 8'h10;

   // modem control fields
   localparam int UMDP_MC_DTR = 0;
   localparam int UMDP_MC_RTS = 1;
   localparam int UMDP_MC_OE = 3;

   // modem status: inverted pin levels sit at [7:4]
   localparam int UMDP_MS_LVL_LO = 4;

   // dma control fields
   localparam int UMDP_DMA_FIFO = 0;
   localparam int UMDP_DMA_MULTI = 1;
   localparam int UMDP_DMA_TRIG_LO = 8;
   localparam int UMDP_TRIG_W = 5;

   // status bit of the ring indicator within the modem vector
   localparam int UMDP_RI_BIT = 2;

   // reset values
   localparam logic [7:0] UMDP_MCTRL_RST = 8'h00;
   localparam logic [15:0] UMDP_DMA_RST = 16'h0000;
   localparam logic [3:0] UMDP_IRQ_RST = 4'h0;

   // fifo depth and holding register depth
   localparam logic [4:0] UMDP_FIFO_DEPTH = 5'h10;
   localparam logic [4:0] UMDP_HOLD_DEPTH = 5'h01;

   // axi responses
   localparam logic [1:0] UMDP_RESP_OKAY = 2'h0;
   localparam logic [1:0] UMDP_RESP_SLVERR = 2'h2;

   // modem inputs, active low at the pins; bit 0 is clear-to-send
   typedef struct packed {
      logic cd;
      logic ri;
      logic dsr;
      logic cts;
   } umdp_modem_t;

   // bus channel state, one-hot
   typedef enum logic [1:0] {
      UMDP_IDLE = 2'b01,
      UMDP_BUSY = 2'b10
   } umdp_st_t;

endpackage : umdp_pkg

/* design/umdp_pin_logic.sv */
// umdp_pin_logic: modem control and status pins, dma ready pins,
// interrupt pin three-state control and serial pin reset gating
// assumes: fifo counts and serial tx bit come from logic on aclk,
// modem and rx pins are asynchronous, master obeys axi4-lite
`timescale 1ns/1ps

// Notes on behaviour
// - control bit three set: drive interrupt, output two low
// - control bit three clear: interrupt floats, output two high
// - reset returns registers and outputs to defaults
// - during reset tx disabled, rx ignored
// - receive ready low when characters are waiting and not below trigger
// - receive ready high when empty or below trigger
// - transmit ready low while a location is free
// - transmit ready high when transmit store full
// - clear-to-send shown in status bit four only
// - control bit zero set drives terminal-ready low
// - terminal-ready high after clearing bit or reset
// - control bit one drives request-to-send, high after reset
// - ring indicator rising edge raises interrupt request
// - serial transmit rests high in reset, idle, disabled
module umdp_pin_logic (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   // axi4-lite slave
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // occupancy from the fifo datapath
   input wire logic [4:0] rx_count,
   input wire logic [4:0] tx_count,
   // serial datapath
   input wire logic tx_bit,
   input wire logic tx_enable,
   output logic serial_tx,
   input wire logic serial_rx_pin,
   output logic rx_bit,
   // modem pins
   input wire umdp_pkg::umdp_modem_t modem_in_n,
   output logic dtr_n,
   output logic rts_n,
   output logic user_output_two_n,
   // interrupt pin as output and enable, enable low while driving
   output logic chan_int,
   output logic chan_int_oe_n,
   output logic irq,
   // dma pins
   output logic rx_ready_n,
   output logic tx_ready_n
);

   // register state
   logic [7:0] modem_control_reg;
   logic [15:0] dma_ctrl;
   logic [3:0] irq_status;
   logic [3:0] irq_mask;

   // synchronisers and edge history
   logic [3:0] modem_s1;
   logic [3:0] modem_s2;
   logic [3:0] modem_prev;
   logic rx_s1;
   logic rx_s2;

   // bus state
   umdp_pkg::umdp_st_t wr_st;
   umdp_pkg::umdp_st_t rd_st;
   logic [7:0] wr_addr;
   logic [31:0] wr_data;
   logic [31:0] wr_mask;

   // byte enables widened to a bit mask
   wire [31:0] strb_mask = {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}},
                            {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};

   // write decode; registers hit only after both channels are taken
   wire wr_take = s_axi_awvalid & s_axi_awready;
   wire wr_fire = (wr_st == umdp_pkg::UMDP_BUSY) & ~s_axi_bvalid;
   wire wr_mctrl = wr_fire & (wr_addr == umdp_pkg::UMDP_OFF_MCTRL);
   wire wr_dma = wr_fire & (wr_addr == umdp_pkg::UMDP_OFF_DMA);
   wire wr_mask_hit = wr_fire & (wr_addr == umdp_pkg::UMDP_OFF_IRQ_MASK);
   wire wr_mapped = (wr_addr == umdp_pkg::UMDP_OFF_MCTRL) |
                    (wr_addr == umdp_pkg::UMDP_OFF_MSTAT) |
                    (wr_addr == umdp_pkg::UMDP_OFF_DMA) |
                    (wr_addr == umdp_pkg::UMDP_OFF_IRQ_STAT) |
                    (wr_addr == umdp_pkg::UMDP_OFF_IRQ_MASK);

   // merged write values under the byte mask
   wire [31:0] mctrl_wr = ({24'h000000, modem_control_reg} & ~wr_mask) |
                          (wr_data & wr_mask);
   wire [31:0] dma_wr = ({16'h0000, dma_ctrl} & ~wr_mask) | (wr_data & wr_mask);
   wire [31:0] mask_wr = ({28'h0000000, irq_mask} & ~wr_mask) |
                         (wr_data & wr_mask);

   // read decode
   wire rd_take = s_axi_arvalid & s_axi_arready;
   wire rd_start = (rd_st == umdp_pkg::UMDP_IDLE) & s_axi_arvalid & ~s_axi_arready;
   wire rd_stat = rd_start & (s_axi_araddr == umdp_pkg::UMDP_OFF_IRQ_STAT);
   wire rd_hit_mc = s_axi_araddr == umdp_pkg::UMDP_OFF_MCTRL;
   wire rd_hit_ms = s_axi_araddr == umdp_pkg::UMDP_OFF_MSTAT;
   wire rd_hit_dma = s_axi_araddr == umdp_pkg::UMDP_OFF_DMA;
   wire rd_hit_is = s_axi_araddr == umdp_pkg::UMDP_OFF_IRQ_STAT;
   wire rd_hit_im = s_axi_araddr == umdp_pkg::UMDP_OFF_IRQ_MASK;
   wire rd_mapped = rd_hit_mc | rd_hit_ms | rd_hit_dma | rd_hit_is | rd_hit_im;

   // status shows asserted modem lines as ones, clear-to-send at bit four
   wire [7:0] modem_status_reg = {~modem_s2, 4'h0};
   wire [31:0] rd_mux = rd_hit_mc ? {24'h000000, modem_control_reg} :
                        rd_hit_ms ? {24'h000000, modem_status_reg} :
                        rd_hit_dma ? {16'h0000, dma_ctrl} :
                        rd_hit_is ? {28'h0000000, irq_status} :
                        rd_hit_im ? {28'h0000000, irq_mask} : 32'h00000000;

   // modem events: ring on the pin's rising edge, others on any change
   wire [3:0] modem_event; // one net, each bit driven by its own generate branch
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi = gi + 1) begin : g_evt
         if (gi == umdp_pkg::UMDP_RI_BIT) begin : g_ri
            assign modem_event[gi] = modem_s2[gi] & ~modem_prev[gi];
         end else begin : g_chg
            assign modem_event[gi] = modem_s2[gi] ^ modem_prev[gi];
         end
      end
   endgenerate

   // set wins over clear-on-read so no event is lost
   wire [3:0] next_irq_status = (irq_status & {4{~rd_stat}}) | modem_event;

   // dma thresholds; the holding register counts as a one-deep store
   wire fifo_mode = dma_ctrl[umdp_pkg::UMDP_DMA_FIFO];
   wire multi_mode = fifo_mode & dma_ctrl[umdp_pkg::UMDP_DMA_MULTI];
   wire [4:0] trig = dma_ctrl[umdp_pkg::UMDP_DMA_TRIG_LO +: umdp_pkg::UMDP_TRIG_W];
   wire [4:0] tx_depth = fifo_mode ? umdp_pkg::UMDP_FIFO_DEPTH : umdp_pkg::UMDP_HOLD_DEPTH;
   wire rx_empty = rx_count == 5'h00;
   wire rx_below = multi_mode & (rx_count < trig);
   wire next_rx_ready_n = rx_empty | rx_below;
   wire next_tx_ready_n = ~(tx_count < tx_depth);

   // modem and rx synchronisers; first stage feeds only the second
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         modem_s1 <= 4'hF;
         modem_s2 <= 4'hF;
         modem_prev <= 4'hF;
         rx_s1 <= 1'b1;
         rx_s2 <= 1'b1;
      end else if (ce) begin
         modem_s1 <= modem_in_n;
         modem_s2 <= modem_s1;
         modem_prev <= modem_s2;
         rx_s1 <= serial_rx_pin;
         rx_s2 <= rx_s1;
      end
   end

   // write channel: waits for address and data together, then answers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wr_st <= umdp_pkg::UMDP_IDLE;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= umdp_pkg::UMDP_RESP_OKAY;
         wr_addr <= 8'h00;
         wr_data <= 32'h00000000;
         wr_mask <= 32'h00000000;
      end else if (ce) begin
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         case (wr_st)
            umdp_pkg::UMDP_IDLE: begin
               if (s_axi_awvalid && s_axi_wvalid && !s_axi_awready) begin
                  s_axi_awready <= 1'b1;
                  s_axi_wready <= 1'b1;
               end
               if (wr_take) begin
                  wr_addr <= s_axi_awaddr;
                  wr_data <= s_axi_wdata;
                  wr_mask <= strb_mask;
                  wr_st <= umdp_pkg::UMDP_BUSY;
               end
            end
            umdp_pkg::UMDP_BUSY: begin
               if (!s_axi_bvalid) begin
                  s_axi_bvalid <= 1'b1;
                  s_axi_bresp <= wr_mapped ? umdp_pkg::UMDP_RESP_OKAY :
                                 umdp_pkg::UMDP_RESP_SLVERR;
               end else if (s_axi_bready) begin
                  s_axi_bvalid <= 1'b0;
                  wr_st <= umdp_pkg::UMDP_IDLE;
               end
            end
            default: wr_st <= umdp_pkg::UMDP_IDLE;
         endcase
      end
   end

   // read channel: data captured on rd_start with arready, valid one cycle later
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rd_st <= umdp_pkg::UMDP_IDLE;
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= umdp_pkg::UMDP_RESP_OKAY;
      end else if (ce) begin
         s_axi_arready <= 1'b0;
         case (rd_st)
            umdp_pkg::UMDP_IDLE: begin
               if (rd_start) begin
                  s_axi_arready <= 1'b1;
                  s_axi_rdata <= rd_mux;
                  s_axi_rresp <= rd_mapped ? umdp_pkg::UMDP_RESP_OKAY :
                                 umdp_pkg::UMDP_RESP_SLVERR;
               end
               if (rd_take) begin
                  s_axi_rvalid <= 1'b1;
                  rd_st <= umdp_pkg::UMDP_BUSY;
               end
            end
            umdp_pkg::UMDP_BUSY: begin
               if (s_axi_rready) begin
                  s_axi_rvalid <= 1'b0;
                  rd_st <= umdp_pkg::UMDP_IDLE;
               end
            end
            default: rd_st <= umdp_pkg::UMDP_IDLE;
         endcase
      end
   end

   // software registers; reset clears control so the pins go passive
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         modem_control_reg <= umdp_pkg::UMDP_MCTRL_RST;
         dma_ctrl <= umdp_pkg::UMDP_DMA_RST;
         irq_mask <= umdp_pkg::UMDP_IRQ_RST;
         irq_status <= umdp_pkg::UMDP_IRQ_RST;
      end else if (ce) begin
         if (wr_mctrl) begin
            modem_control_reg <= mctrl_wr[7:0];
         end
         if (wr_dma) begin
            dma_ctrl <= dma_wr[15:0];
         end
         if (wr_mask_hit) begin
            irq_mask <= mask_wr[3:0];
         end
         irq_status <= next_irq_status;
      end
   end

   // pin outputs, all registered; one cycle behind their control bits
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         dtr_n <= 1'b1;
         rts_n <= 1'b1;
         user_output_two_n <= 1'b1;
         chan_int_oe_n <= 1'b1;
         chan_int <= 1'b0;
         irq <= 1'b0;
         rx_ready_n <= 1'b1;
         tx_ready_n <= 1'b1;
      end else if (ce) begin
         dtr_n <= ~modem_control_reg[umdp_pkg::UMDP_MC_DTR];
         rts_n <= ~modem_control_reg[umdp_pkg::UMDP_MC_RTS];
         user_output_two_n <= ~modem_control_reg[umdp_pkg::UMDP_MC_OE];
         chan_int_oe_n <= ~modem_control_reg[umdp_pkg::UMDP_MC_OE];
         chan_int <= |(irq_status & irq_mask);
         irq <= |(irq_status & irq_mask);
         rx_ready_n <= next_rx_ready_n;
         tx_ready_n <= next_tx_ready_n;
      end
   end

   // serial pins; rts and cts never gate the transmitter
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         serial_tx <= 1'b1;
         rx_bit <= 1'b1;
      end else if (ce) begin
         serial_tx <= tx_enable ? tx_bit : 1'b1;
         rx_bit <= rx_s2;
      end
   end

endmodule : umdp_pin_logic

/* verif/umdp_pin_chk.sv */
// umdp_pin_chk: port assertions of the modem, dma and pin logic
// assumes: bound to umdp_pin_logic, one clock, reset aresetn low
`timescale 1ns/1ps
module umdp_pin_chk (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   input wire logic [4:0] rx_count,
   input wire logic [4:0] tx_count,
   input wire logic tx_bit,
   input wire logic tx_enable,
   input wire logic serial_tx,
   input wire logic serial_rx_pin,
   input wire logic rx_bit,
   input wire logic dtr_n,
   input wire logic rts_n,
   input wire logic user_output_two_n,
   input wire logic chan_int,
   input wire logic chan_int_oe_n,
   input wire logic irq,
   input wire logic rx_ready_n,
   input wire logic tx_ready_n
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // reset wins whatever the inputs do, so no disable here
   rst_out_a: assert property (disable iff (1'h0)
      !aresetn |=> dtr_n && rts_n && user_output_two_n && chan_int_oe_n && serial_tx
      && rx_bit && !irq && rx_ready_n && tx_ready_n) else $error("reset defaults wrong");
   out_two_a: assert property (
      user_output_two_n == chan_int_oe_n) else $error("output two and enable differ");
   int_drive_a: assert property (
      !chan_int_oe_n |-> chan_int == irq) else $error("driven interrupt wrong");
   // past values guard the first edge after reset
   rx_empty_a: assert property (
      $past(aresetn) && $past(ce) && $past(rx_count) == 5'h00 |-> rx_ready_n)
      else $error("rx ready low while empty");
   tx_free_a: assert property (
      $past(aresetn) && $past(ce) && $past(tx_count) == 5'h00 |-> !tx_ready_n)
      else $error("tx ready high while empty");
   tx_full_a: assert property (
      $past(aresetn) && $past(ce) && $past(tx_count) >= 5'h10 |-> tx_ready_n)
      else $error("tx ready low while full");
   tx_line_a: assert property (
      $past(aresetn) && $past(ce) |->
      serial_tx == ($past(tx_enable) ? $past(tx_bit) : 1'h1)) else $error("tx line wrong");
   rx_sync_a: assert property (
      (aresetn && ce) [*3] ##1 1'h1 |-> rx_bit == $past(serial_rx_pin, 3))
      else $error("rx sync wrong");
endmodule : umdp_pin_chk
bind umdp_pin_logic umdp_pin_chk chk (.aclk, .aresetn, .ce, .rx_count, .tx_count, .tx_bit,
   .tx_enable, .serial_tx, .serial_rx_pin, .rx_bit, .dtr_n, .rts_n, .user_output_two_n,
   .chan_int, .chan_int_oe_n, .irq, .rx_ready_n, .tx_ready_n);

/* verif/umdp_modem_model.sv */
// umdp_modem_model: data set side of the modem pins
// assumes: bench sets the asserted status, pins follow one edge later
`timescale 1ns/1ps
module umdp_modem_model (
   input wire logic aclk,
   input wire logic [3:0] asrt,
   output umdp_pkg::umdp_modem_t modem_in_n
);
   // pins are active low: an asserted status pulls its pin to zero
   initial modem_in_n = umdp_pkg::umdp_modem_t'(4'hF);
   always @(posedge aclk) begin
      modem_in_n <= umdp_pkg::umdp_modem_t'(~asrt);
   end
endmodule : umdp_modem_model

/* verif/uart_modem_dma_pin_logic_test.sv */
// uart_modem_dma_pin_logic_test: self-checking bench of the pin logic
// assumes: package, design and modem model compiled first
`timescale 1ns/1ps
`define CHK(n, e, s) begin num_checks++; if ((s) !== (e)) begin n_errors++; \
   $display("Error %s exp %0h got %0h", n, e, s); end end
module uart_modem_dma_pin_logic_test;
   logic aclk = 1'h0;
   logic aresetn = 1'h0;
   logic ce = 1'h1;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
   logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, r, d, seed = 32'hA191;
   logic [3:0] s_axi_wstrb = 4'hF, asrt = 4'h0;
   logic [4:0] rx_count = 5'h00, tx_count = 5'h00;
   logic tx_bit = 1'h0, tx_enable = 1'h1, serial_rx_pin = 1'h0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic serial_tx, rx_bit, dtr_n, rts_n, user_output_two_n, chan_int, chan_int_oe_n, irq;
   logic rx_ready_n, tx_ready_n, e_rx, e_tx;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [7:0] c;
   umdp_pkg::umdp_modem_t modem_in_n;
   int n_errors = 0, num_checks = 0, cyc = 0, i;
   umdp_pin_logic uut (.aclk, .aresetn, .ce, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .rx_count, .tx_count, .tx_bit, .tx_enable,
      .serial_tx, .serial_rx_pin, .rx_bit, .modem_in_n, .dtr_n, .rts_n, .user_output_two_n,
      .chan_int, .chan_int_oe_n, .irq, .rx_ready_n, .tx_ready_n);
   umdp_modem_model modem (.aclk, .asrt, .modem_in_n);
   always #2.5 aclk = ~aclk;
   // hang guard, well above the few hundred cycles the run needs
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_errors++;
         end_sim();
      end
   end
   function logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd
   function logic [1:0] resp(input logic [7:0] a);
      return (a <= 8'h10 && a[1:0] == 2'h0) ? 2'h0 : 2'h2;
   endfunction : resp
   // bus tasks end one edge late so no strobe is set twice in a step
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
      do @(posedge aclk); while (s_axi_awready !== 1'h1);
      `CHK("wready", 1'h1, s_axi_wready)
      {s_axi_awvalid, s_axi_wvalid} <= 2'h0;
      do @(posedge aclk); while (s_axi_bvalid !== 1'h1);
      s_axi_bready <= 1'h0;
      `CHK("bresp", resp(a), s_axi_bresp)
      @(posedge aclk);
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [31:0] v);
      s_axi_araddr <= a;
      {s_axi_arvalid, s_axi_rready} <= 2'h3;
      do @(posedge aclk); while (s_axi_arready !== 1'h1);
      s_axi_arvalid <= 1'h0;
      do @(posedge aclk); while (s_axi_rvalid !== 1'h1);
      s_axi_rready <= 1'h0;
      v = s_axi_rdata;
      `CHK("rresp", resp(a), s_axi_rresp)
      @(posedge aclk);
   endtask : rd
   task automatic dflt();
      `CHK("rst pins", 6'h3F, {dtr_n, rts_n, user_output_two_n, chan_int_oe_n, serial_tx, rx_bit})
      `CHK("rst dma", 3'h6, {rx_ready_n, tx_ready_n, irq})
   endtask : dflt
   task automatic end_sim();
      if (n_errors == 0 && num_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : end_sim
   // tx enabled with a low bit and rx low: reset must still hold both lines
   initial begin
      repeat (16) @(posedge aclk);
      dflt();
      aresetn <= 1'h1;
      @(posedge aclk);
      for (i = 0; i < 8; i++) begin
         r = rnd();
         c = (r[7:0] & 8'hF4) | {4'h0, i[2], 1'h0, i[1:0]};
         wr(8'h00, {24'h0, c});
         wr(8'h04, 32'hFF);
         `CHK("ctl pins", {~c[3], ~c[3], ~c[1], ~c[0]}, {user_output_two_n, chan_int_oe_n, rts_n, dtr_n})
         rd(8'h00, d);
         `CHK("ctl reg", {24'h0, c}, d)
      end
      for (i = 0; i < 4; i++) begin
         r = rnd();
         asrt <= r[3:0];
         repeat (4) @(posedge aclk);
         rd(8'h04, d);
         `CHK("mstat", {24'h0, r[3:0], 4'h0}, d)
      end
      // ring: only the release of the pin counts, masked or not
      for (i = 0; i < 2; i++) begin
         wr(8'h10, i ? 32'h0 : 32'h4);
         asrt <= 4'h4;
         repeat (8) @(posedge aclk);
         rd(8'h0C, d);
         `CHK("irq hold", 1'h0, irq)
         asrt <= 4'h0;
         repeat (8) @(posedge aclk);
         `CHK("irq ring", i ? 2'h0 : 2'h3, {irq, chan_int})
         rd(8'h0C, d);
         `CHK("istat", 32'h4, d)
         `CHK("irq clr", 1'h0, irq)
      end
      rd(8'h20, d);
      `CHK("unmapped", 32'h0, d)
      wr(8'h21, 32'h0);
      // occupancy sweep with boundaries forced every fourth pass
      for (i = 0; i < 32; i++) begin
         r = rnd();
         wr(8'h08, {19'h0, r[12:8], 6'h0, r[1:0]});
         rx_count <= (i % 4 == 0) ? 5'h00 : 5'(r[20:16] % 17);
         tx_count <= (i % 4 == 1) ? 5'h10 : 5'(r[28:24] % 17);
         repeat (2) @(posedge aclk);
         e_rx = (rx_count == 0) || (r[0] && r[1] && rx_count < r[12:8]);
         e_tx = !(tx_count < (r[0] ? 16 : 1));
         `CHK("rx rdy", e_rx, rx_ready_n)
         `CHK("tx rdy", e_tx, tx_ready_n)
      end
      for (i = 0; i < 16; i++) begin
         r = rnd();
         {asrt, tx_enable, tx_bit, serial_rx_pin} <= r[6:0];
         repeat (4) @(posedge aclk);
         `CHK("tx line", r[2] ? r[1] : 1'h1, serial_tx)
         `CHK("rx line", r[0], rx_bit)
      end
      // clock enable low freezes the line, then it catches up
      ce <= 1'h0;
      tx_enable <= 1'h1;
      tx_bit <= ~serial_tx;
      repeat (4) @(posedge aclk);
      `CHK("ce hold", ~tx_bit, serial_tx)
      ce <= 1'h1;
      repeat (2) @(posedge aclk);
      `CHK("ce run", tx_bit, serial_tx)
      wr(8'h00, 32'h0B);
      {tx_enable, tx_bit, serial_rx_pin} <= 3'h4;
      aresetn <= 1'h0;
      repeat (2) @(posedge aclk);
      dflt();
      aresetn <= 1'h1;
      @(posedge aclk);
      rd(8'h00, d);
      `CHK("ctl rst", 32'h0, d)
      end_sim();
   end
endmodule : uart_modem_dma_pin_logic_test
